/* File: dv/clu_sva.sv */
`timescale 1ns/1ns
module clu_sva (
    input wire logic                     core_clk,
    input wire logic                     resetn,
    input wire logic                     hostUp,
    input wire logic                     reqValid,
    input wire clu_pkg::clu_req_t        reqKind,
    input wire logic [1:0]               reqSel,
    input wire logic                     ackValid,
    input wire logic                     muxMode,
    input wire clu_pkg::clu_word_t [3:0] imgWord
);
    logic hupQ_r;
    logic hupQQ_r;

    // ==========================================
    // Power-up history, to excuse the image clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hupQ_r  <= 1'b0;
            hupQQ_r <= 1'b0;
        end else begin
            hupQ_r  <= hostUp;
            hupQQ_r <= hupQ_r;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // ==========================================
    // Link behaviour
    ack_follows_req_a: assert property (reqValid && hostUp |=> ackValid)
        else $error("request without answer");
    ack_has_cause_a: assert property (ackValid |-> $past(reqValid) && $past(hostUp))
        else $error("answer without request");
    one_request_a: assert property (reqValid |=> !reqValid)
        else $error("back to back requests");
    mux_select_a: assert property (ackValid && muxMode |-> imgWord[0][15:14] == $past(reqSel))
        else $error("wrong channel select in word");
    mux_others_a: assert property (ackValid && muxMode |-> $stable(imgWord[3:1]))
        else $error("unused words changed");
    // Clear at power-up lands one edge after the rise is seen
    img_hold_a: assert property (!ackValid && !(hupQ_r && !hupQQ_r) |-> $stable(imgWord))
        else $error("image changed without answer");
    mode_hold_a: assert property (hupQ_r && hupQQ_r |-> $stable(muxMode))
        else $error("mode changed while powered");
    for (genvar i = 0; i < 4; i++) begin : g_word
        over_full_a: assert property (imgWord[i][12] |-> imgWord[i][11:0] == 12'hFFF)
            else $error("over flag without full code");
        under_zero_a: assert property (imgWord[i][13] |-> imgWord[i][11:0] == 12'h000)
            else $error("under flag without zero code");
        four_nosel_a: assert property (ackValid && !muxMode |-> imgWord[i][15:14] == 2'h0)
            else $error("select bits set in four-word mode");
    end

    cover property (ackValid && muxMode);
    cover property (reqValid && reqKind == clu_pkg::CLU_SCAN_END && !muxMode);
    cover property (imgWord[0][12]);
    cover property (imgWord[0][13]);
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ns
module tb;
    logic             core_clk;
    logic             resetn;
    logic [3:0][15:0] loopUa;
    logic             modeSwitch;
    logic [7:0]       awAddr;
    logic             awValid;
    logic             awReady;
    logic [31:0]      wData;
    logic             wValid;
    logic             wReady;
    logic [1:0]       bResp;
    logic             bValid;
    logic [7:0]       arAddr;
    logic             arValid;
    logic             arReady;
    logic [31:0]      rData;
    logic [1:0]       rResp;
    logic             rValid;
    logic             rangeErr;
    int               errors;
    int               n_checks;
    logic [31:0]      seed;
    logic [15:0]      uaV [4];
    logic [15:0]      expW [4];
    logic [15:0]      corner [10];
    logic [31:0]      d;
    logic [31:0]      t;
    logic [1:0]       r;
    logic [1:0]       sel;
    logic             anyFlag;

    clu_link_if link();
    clu_device clu_device_i (.core_clk(core_clk), .resetn(resetn), .link(link),
        .loopUa(loopUa), .modeSwitch(modeSwitch));
    clu_host clu_host_i (.core_clk(core_clk), .resetn(resetn), .link(link),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(1'b1), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(1'b1), .rangeErr(rangeErr));
    clu_sva clu_sva_i (.core_clk(core_clk), .resetn(resetn), .hostUp(link.hostUp),
        .reqValid(link.reqValid), .reqKind(link.reqKind), .reqSel(link.reqSel),
        .ackValid(link.ackValid), .muxMode(link.muxMode), .imgWord(link.imgWord));

    // ==========================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [15:0] exp_word(input logic [15:0] ua);
        logic [27:0] c;
        c = (ua > 16'h4E20) ? 28'h000_0FFF : (ua < 16'h0FA0) ? 28'h000_0000 :
            ((28'(ua) - 28'h000_0FA0) * 28'h000_0FFF) / 28'h000_3E80;
        return {2'h0, ua < 16'h0960, ua > 16'h5654, c[11:0]};
    endfunction

    task give_verdict();
        $display("Checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: word %h, expected %h", $time, got, exp);
        end
    endtask

    task chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: response %h, expected %h", $time, got, exp);
        end
    endtask

    // Handshakes judged on values seen at the rising edge itself
    task axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic done;
        awAddr <= a;
        wData <= v;
        awValid <= 1'b1;
        wValid <= 1'b1;
        done = 1'b0;
        rs = 2'h0;
        while (!done) begin
            @(posedge core_clk);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
            if (bValid) begin
                done = 1'b1;
                rs = bResp;
            end
        end
    endtask

    task axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic done;
        arAddr <= a;
        arValid <= 1'b1;
        done = 1'b0;
        v = 32'h0000_0000;
        rs = 2'h0;
        while (!done) begin
            @(posedge core_clk);
            if (arValid && arReady) arValid <= 1'b0;
            if (rValid) begin
                done = 1'b1;
                v = rData;
                rs = rResp;
            end
        end
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0]  rs;
        axi_rd(a, v, rs);
        chk_word(v, e);
    endtask

    // Busy is polled: a go while busy would be dropped
    task go(input logic [4:0] ctrl);
        logic [31:0] s;
        logic [1:0]  rs;
        int          n;
        axi_wr(8'h00, {27'h000_0000, ctrl}, rs);
        chk_resp(rs, 2'h0);
        n = 0;
        s = 32'h0000_0001;
        while (s[0] && n < 50) begin
            axi_rd(8'h04, s, rs);
            n++;
        end
        chk_word({31'h0000_0000, s[0]}, 32'h0000_0000);
    endtask

    task new_ua(input int k);
        for (int i = 0; i < 4; i++) begin
            t = rnd();
            uaV[i] = (k < 10) ? corner[(k + i) % 10] : 16'(t % 32'h0000_5DC0);
            loopUa[i] <= uaV[i];
        end
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        #600000;
        errors++;
        $display("Error %0t: timeout", $time);
        give_verdict();
    end

    // ==========================================
    // Main sequence
    initial begin
        corner = '{16'h0000, 16'h095F, 16'h0960, 16'h0F9F, 16'h0FA0,
                   16'h4E20, 16'h4E21, 16'h5654, 16'h5655, 16'hFFFF};
        errors = 0;
        n_checks = 0;
        seed = 32'h87d4_af26;
        resetn = 1'b0;
        modeSwitch = 1'b0;
        loopUa = '0;
        awAddr = 8'h00;
        awValid = 1'b0;
        wData = 32'h0000_0000;
        wValid = 1'b0;
        arAddr = 8'h00;
        arValid = 1'b0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        rd_chk(8'h04, 32'h0000_0000);
        rd_chk(8'h08, 32'h0000_0000);
        axi_rd(8'h20, d, r);
        chk_resp(r, 2'h2);
        axi_wr(8'h30, 32'h0000_0011, r);
        chk_resp(r, 2'h2);
        go(5'h10);
        for (int k = 0; k < 40; k++) begin
            new_ua(k);
            t = rnd();
            sel = t[1:0];
            if (k % 3 == 2) begin
                go(5'h12 | (5'(sel) << 2));
                expW[sel] = exp_word(uaV[sel]);
            end else begin
                go(5'h11);
                for (int i = 0; i < 4; i++) expW[i] = exp_word(uaV[i]);
            end
            anyFlag = 1'b0;
            for (int i = 0; i < 4; i++) begin
                rd_chk(8'h08 + 8'(4 * i), {16'h0000, expW[i]});
                anyFlag = anyFlag | expW[i][12] | expW[i][13];
            end
            chk_word({31'h0000_0000, rangeErr}, {31'h0000_0000, anyFlag});
        end
        go(5'h00);
        modeSwitch <= 1'b1;
        repeat (4) @(posedge core_clk);
        go(5'h10);
        axi_rd(8'h04, d, r);
        chk_word({31'h0000_0000, d[1]}, 32'h0000_0001);
        for (int k = 0; k < 24; k++) begin
            new_ua(k);
            sel = 2'(k);
            go((k < 12 ? 5'h11 : 5'h12) | (5'(sel) << 2));
            expW[0] = exp_word(uaV[sel]);
            t = {16'h0000, sel, expW[0][13:0]};
            rd_chk(8'h08, t);
        end
        modeSwitch <= 1'b0;
        repeat (4) @(posedge core_clk);
        axi_rd(8'h04, d, r);
        chk_word({31'h0000_0000, d[1]}, 32'h0000_0001);
        give_verdict();
    end
endmodule

/* File: logic/clu_defines.svh */
`ifndef CLU_DEFINES_SVH
`define CLU_DEFINES_SVH

// ==========================================
// Channel word layout
`define CLU_NCH          4
`define CLU_CODE_W       12
`define CLU_WORD_W       16
`define CLU_FULL_CODE    12'hFFF
`define CLU_ZERO_CODE    12'h000
`define CLU_OVR_BIT      12
`define CLU_UND_BIT      13
`define CLU_SEL_LSB      14

// ==========================================
// Loop current thresholds, microamps
`define CLU_LOW_UA       16'h0FA0
`define CLU_HIGH_UA      16'h4E20
`define CLU_OVR_UA       16'h5654
`define CLU_UND_UA       16'h0960
`define CLU_SPAN_UA      28'h000_3E80
`define CLU_FULL_MUL     28'h000_0FFF

// ==========================================
// Controller register offsets and fields
`define CLU_OFS_CTRL     8'h00
`define CLU_OFS_STAT     8'h04
`define CLU_OFS_IMG0     8'h08
`define CLU_OFS_IMG3     8'h14
`define CLU_CTRL_SCAN    0
`define CLU_CTRL_MID     1
`define CLU_CTRL_SEL_LSB 2
`define CLU_CTRL_UP      4
`define CLU_STAT_BUSY    0
`define CLU_STAT_MUX     1
`define CLU_STAT_ERR     2
`define CLU_STAT_UP      3
`define CLU_RESP_OKAY    2'h0
`define CLU_RESP_SLVERR  2'h2
`define CLU_WORD_RST     16'h0000
`define CLU_DATA_RST     32'h0000_0000

`endif

/* File: logic/clu_device.sv */
// Functional notes
// - Above 20 mA result saturates at 4095
// - Above about 22.1 mA set over-range bit 12
// - Below 4 mA result forced to zero
// - Below about 2.4 mA set under-range flag
// - Mux mode: one word, selected channel data
// - Host writes channel select before update
// - Mux mode: scan end refreshes selected channel
// - Four-register mode: four words, all refreshed at scan end
// - Mid-scan reads refresh any channel on demand
// - Host flags error when range bits set
// - Code low 12 bits, over 1000H, under 2000H
// - Mode switch sampled at host power-up
`timescale 1ns/1ns
`include "clu_defines.svh"

module clu_device (
    input  wire logic                 core_clk,
    input  wire logic                 resetn,
    clu_link_if.dev                   link,
    input  wire logic [3:0][15:0]     loopUa,
    input  wire logic                 modeSwitch
);

    // ==========================================
    // Conversion helpers

    // Returns {under, over, code} for one loop current sample
    function automatic logic [13:0] cluConv(input logic [15:0] ua);
        logic [27:0] prod;
        logic [27:0] quo;
        logic [11:0] code;
        logic        over;
        logic        under;
        prod  = 28'h000_0000;
        quo   = 28'h000_0000;
        code  = `CLU_ZERO_CODE;
        if (ua < `CLU_LOW_UA) begin
            code = `CLU_ZERO_CODE;
        end else if (ua > `CLU_HIGH_UA) begin
            code = `CLU_FULL_CODE;
        end else begin
            // Exact divide keeps the map monotonic end to end
            prod = {12'h000, 16'(ua - `CLU_LOW_UA)} * `CLU_FULL_MUL;
            quo  = prod / `CLU_SPAN_UA;
            code = quo[11:0];
        end
        // Recomputed on every update, so a flag drops once back in range
        over  = (ua > `CLU_OVR_UA);
        under = (ua < `CLU_UND_UA);
        return {under, over, code};
    endfunction

    // Packs one channel word: select, under, over, code
    function automatic clu_pkg::clu_word_t cluPack(
        input logic [13:0] conv,
        input logic [1:0]  sel
    );
        clu_pkg::clu_word_t w;
        w = `CLU_WORD_RST;
        w[`CLU_CODE_W-1:0]  = conv[11:0];
        w[`CLU_OVR_BIT]     = conv[12];
        w[`CLU_UND_BIT]     = conv[13];
        w[`CLU_SEL_LSB+:2]  = sel;
        return w;
    endfunction

    // ==========================================
    // Mode switch synchroniser
    logic                          modeMeta_r;
    logic                          modeSync_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            modeMeta_r <= 1'b0;
            modeSync_r <= 1'b0;
        end else begin
            modeMeta_r <= modeSwitch;
            modeSync_r <= modeMeta_r;
        end
    end

    // ==========================================
    // Mode latch at host power-up
    logic                          hostUpPrev_r;
    logic                          muxMode_r;
    logic                          hostRise;

    assign hostRise = link.hostUp && !hostUpPrev_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hostUpPrev_r <= 1'b0;
        end else begin
            hostUpPrev_r <= link.hostUp;
        end
    end

    // Switch moves while the host runs are ignored until next power-up
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            muxMode_r <= 1'b0;
        end else if (hostRise) begin
            muxMode_r <= modeSync_r;
        end
    end

    assign link.muxMode = muxMode_r;

    // ==========================================
    // Update requests
    logic                          reqTake;
    logic                          ackValid_r;
    logic [1:0]                    chanSel_r;

    // Requests before power-up are dropped without answer
    assign reqTake = link.reqValid && link.hostUp;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ackValid_r <= 1'b0;
        end else begin
            ackValid_r <= reqTake;
        end
    end

    assign link.ackValid = ackValid_r;

    // Channel select travels with every request from the host
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            chanSel_r <= 2'b00;
        end else if (reqTake) begin
            chanSel_r <= link.reqSel;
        end
    end

    // ==========================================
    // Image words
    logic [3:0][13:0]              conv;
    clu_pkg::clu_word_t [3:0]      img_r;
    clu_pkg::clu_word_t [3:0]      img_nxt;

    always_comb begin
        for (int ch = 0; ch < `CLU_NCH; ch++) begin
            conv[ch] = cluConv(loopUa[ch]);
        end
    end

    always_comb begin
        img_nxt = img_r;
        if (reqTake) begin
            if (muxMode_r) begin
                // One word only, filled from the named channel
                img_nxt[0] = cluPack(conv[link.reqSel], link.reqSel);
            end else if (link.reqKind == clu_pkg::CLU_SCAN_END) begin
                for (int ch = 0; ch < `CLU_NCH; ch++) begin
                    img_nxt[ch] = cluPack(conv[ch], 2'b00);
                end
            end else begin
                img_nxt[link.reqSel] = cluPack(conv[link.reqSel], 2'b00);
            end
        end
    end

    // Words 1..3 stay zero in mux mode; the host mirrors all four words on every answer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            img_r <= {4{`CLU_WORD_RST}};
        end else if (hostRise) begin
            img_r <= {4{`CLU_WORD_RST}};
        end else begin
            img_r <= img_nxt;
        end
    end

    assign link.imgWord = img_r;

endmodule

/* File: logic/clu_host.sv */
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`include "clu_defines.svh"

module clu_host (
    input  wire logic              core_clk,
    input  wire logic              resetn,
    clu_link_if.host               link,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   rangeErr
);

    // ==========================================
    // Write channel capture
    logic                          awHeld_r;
    logic                          wHeld_r;
    logic [7:0]                    awAddr_r;
    logic [31:0]                   wData_r;
    logic                          wLane0_r;
    logic                          doWrite;

    assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
    assign doWrite       = awHeld_r && wHeld_r && !s_axi_bvalid;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r  <= `CLU_DATA_RST;
            wLane0_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r  <= 1'b1;
                wData_r  <= s_axi_wdata;
                wLane0_r <= s_axi_wstrb[0];
            end else if (doWrite) begin
                wHeld_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CLU_RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_r == `CLU_OFS_CTRL) ? `CLU_RESP_OKAY : `CLU_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================
    // Control register and update sequencer
    logic                          ctrlHit;
    logic                          hostUp_r;
    logic [1:0]                    chanSel_r;
    logic                          reqValid_r;
    clu_pkg::clu_req_t             reqKind_r;
    clu_pkg::clu_hstate_t          state_r;
    clu_pkg::clu_word_t [3:0]      mirror_r;

    assign ctrlHit = doWrite && wLane0_r && (awAddr_r == `CLU_OFS_CTRL);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hostUp_r  <= 1'b0;
            chanSel_r <= 2'b00;
        end else if (ctrlHit) begin
            hostUp_r  <= wData_r[`CLU_CTRL_UP];
            chanSel_r <= wData_r[`CLU_CTRL_SEL_LSB+:2];
        end
    end

    // Go bits self-clear; a go while busy or powered down is dropped
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r    <= clu_pkg::CLU_IDLE;
            reqValid_r <= 1'b0;
            reqKind_r  <= clu_pkg::CLU_SCAN_END;
        end else begin
            unique case (state_r)
                clu_pkg::CLU_IDLE: begin
                    if (ctrlHit && hostUp_r
                        && (wData_r[`CLU_CTRL_SCAN] || wData_r[`CLU_CTRL_MID])) begin
                        reqValid_r <= 1'b1;
                        reqKind_r  <= wData_r[`CLU_CTRL_SCAN] ? clu_pkg::CLU_SCAN_END
                                                               : clu_pkg::CLU_MID_SCAN;
                        state_r    <= clu_pkg::CLU_SEND;
                    end
                end
                clu_pkg::CLU_SEND: begin
                    reqValid_r <= 1'b0;
                    state_r    <= clu_pkg::CLU_WAIT;
                end
                clu_pkg::CLU_WAIT: begin
                    if (link.ackValid || !hostUp_r) begin
                        state_r <= clu_pkg::CLU_IDLE;
                    end
                end
                default: begin
                    state_r    <= clu_pkg::CLU_IDLE;
                    reqValid_r <= 1'b0;
                end
            endcase
        end
    end

    assign link.hostUp   = hostUp_r;
    assign link.reqValid = reqValid_r;
    assign link.reqKind  = reqKind_r;
    assign link.reqSel   = chanSel_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mirror_r <= {4{`CLU_WORD_RST}};
        end else if (link.ackValid) begin
            mirror_r <= link.imgWord;
        end
    end

    // Any over or under bit in the image raises the error output
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rangeErr <= 1'b0;
        end else begin
            rangeErr <= |{mirror_r[0][`CLU_UND_BIT:`CLU_OVR_BIT],
                          mirror_r[1][`CLU_UND_BIT:`CLU_OVR_BIT],
                          mirror_r[2][`CLU_UND_BIT:`CLU_OVR_BIT],
                          mirror_r[3][`CLU_UND_BIT:`CLU_OVR_BIT]};
        end
    end

    // ==========================================
    // Read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= `CLU_DATA_RST;
            s_axi_rresp  <= `CLU_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `CLU_RESP_OKAY;
            s_axi_rdata  <= `CLU_DATA_RST;
            if (s_axi_araddr == `CLU_OFS_CTRL) begin
                s_axi_rdata[`CLU_CTRL_SEL_LSB+:2] <= chanSel_r;
                s_axi_rdata[`CLU_CTRL_UP]         <= hostUp_r;
            end else if (s_axi_araddr == `CLU_OFS_STAT) begin
                s_axi_rdata[`CLU_STAT_BUSY] <= (state_r != clu_pkg::CLU_IDLE);
                s_axi_rdata[`CLU_STAT_MUX]  <= link.muxMode;
                s_axi_rdata[`CLU_STAT_ERR]  <= rangeErr;
                s_axi_rdata[`CLU_STAT_UP]   <= hostUp_r;
            end else if (s_axi_araddr >= `CLU_OFS_IMG0 && s_axi_araddr <= `CLU_OFS_IMG3
                         && s_axi_araddr[1:0] == 2'b00) begin
                s_axi_rdata[15:0] <= mirror_r[3'(s_axi_araddr[4:2] - 3'd2)];
            end else begin
                s_axi_rresp <= `CLU_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

/* File: logic/clu_link_if.sv */
`timescale 1ns/1ns
interface clu_link_if;
    logic                          hostUp;
    logic                          reqValid;
    clu_pkg::clu_req_t             reqKind;
    logic [1:0]                    reqSel;
    logic                          ackValid;
    logic                          muxMode;
    clu_pkg::clu_word_t [3:0]      imgWord;

    modport dev (
        input  hostUp,
        input  reqValid,
        input  reqKind,
        input  reqSel,
        output ackValid,
        output muxMode,
        output imgWord
    );

    modport host (
        output hostUp,
        output reqValid,
        output reqKind,
        output reqSel,
        input  ackValid,
        input  muxMode,
        input  imgWord
    );
endinterface

/* File: logic/clu_pkg.sv */
package clu_pkg;

    typedef logic [15:0] clu_word_t;

    typedef enum logic {
        CLU_SCAN_END = 1'b0,
        CLU_MID_SCAN = 1'b1
    } clu_req_t;

    typedef enum logic [1:0] {
        CLU_IDLE = 2'b00,
        CLU_SEND = 2'b01,
        CLU_WAIT = 2'b10
    } clu_hstate_t;

endpackage
